// >>> logic/cell_balance_regs.svh
// register offsets, field positions, reset values and timing figures of the balance block
// assumes a 9-bit register address split into a 3-bit page and a 6-bit offset
`ifndef CELL_BALANCE_REGS_SVH
`define CELL_BALANCE_REGS_SVH

`define PAGE_CONFIG          3'h2
`define PAGE_COMMAND         3'h3

`define OFF_BALANCE_SETUP    6'h13
`define OFF_CELL_SELECT      6'h14
`define OFF_WDT_BAL_TIME     6'h15
`define OFF_DEVICE_SETUP     6'h19
`define OFF_BAL_VALUE_FIRST  6'h20
`define OFF_BAL_VALUE_LAST   6'h37

`define CMD_BALANCE_ENABLE   6'h10
`define CMD_BALANCE_INHIBIT  6'h11

`define MODE_LSB             0
`define MODE_MSB             1
`define WAIT_LSB             2
`define WAIT_MSB             4
`define POINTER_LSB          5
`define POINTER_MSB          8
`define ENABLE_BIT           9
`define BAL_TIME_LSB         7
`define BAL_TIME_MSB         13
`define MEASURE_PAUSE_BIT    7

`define SETUP_RESET          10'h000
`define WDT_BAL_TIME_RESET   14'h0000

`define CLK_PERIOD_NS        100
`define TICK_PERIOD_NS       1000000000
`define BAL_TIME_UNIT_S      20
`define WAIT_UNIT_S          2

`endif

// >>> logic/cell_balance_pkg.sv
// types shared by the balance controller files
// assumes nothing of its surroundings
package cell_balance_pkg;

  typedef enum logic [1:0] {
    MODE_OFF    = 2'b00,
    MODE_MANUAL = 2'b01,
    MODE_TIMED  = 2'b10,
    MODE_AUTO   = 2'b11
  } bal_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_LOAD  = 3'b010,
    ST_ON    = 3'b011,
    ST_WAIT  = 3'b100,
    ST_DONE  = 3'b101
  } bal_state_e;

  // one register access; a command is any access to the command page
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [2:0]  page;
    logic [5:0]  addr;
    logic [13:0] wdata;
  } reg_req_s;

  typedef logic [11:0][13:0] cell_volt_t;

endpackage

// >>> logic/cell_select_mem.sv
// cell select instances, one per status pointer value, with two registered read ports
// assumes one clock, synchronous active-low reset and a freezing clock enable
`timescale 1ns/1ps
`default_nettype none
module cell_select_mem #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr_a,
  output logic      [WIDTH-1:0] rd_data_a,
  input  wire logic [AW-1:0]    rd_addr_b,
  output logic      [WIDTH-1:0] rd_data_b
);

  logic [WIDTH-1:0] mem [DEPTH];

  // cleared on reset so an unloaded sequence reads as its own end marker
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      rd_data_a <= '0;
      rd_data_b <= '0;
    end else if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
    end
  end

endmodule // cell_select_mem
`default_nettype wire

// >>> logic/cell_balance_ctrl.sv
// balance switch controller: setup registers, manual, timed and automatic balancing
// assumes register accesses and cell readings synchronous to ref_clk; ce freezes everything
`timescale 1ns/1ps
`default_nettype none
`include "cell_balance_regs.svh"

module cell_balance_ctrl
  import cell_balance_pkg::*;
#(
  parameter int CELLS       = 12,
  parameter int TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire reg_req_s    reg_req,
  input  wire cell_volt_t  cell_volt,
  input  wire logic        meas_busy,
  output logic [13:0]      reg_rdata,
  output logic             reg_rvalid,
  output logic [11:0]      balance_switch,
  output logic             balance_busy,
  output logic             balance_done
);

  function automatic logic hit(input reg_req_s r, input logic [2:0] pg, input logic [5:0] ad);
    hit = (r.page == pg) && (r.addr == ad);
  endfunction

  // setup, time and device setup registers
  logic [9:0]  setup;
  logic [13:0] wdt_time;
  logic        pause_en;
  logic [9:0]  next_setup;
  logic [13:0] next_wdt_time;
  logic        next_pause_en;
  logic        cfg_wr;
  logic        cmd_acc;

  assign cfg_wr  = reg_req.wr && (reg_req.page == `PAGE_CONFIG);
  assign cmd_acc = (reg_req.wr || reg_req.rd) && (reg_req.page == `PAGE_COMMAND);

  always_comb begin
    next_setup    = setup;
    next_wdt_time = wdt_time;
    next_pause_en = pause_en;
    if (cfg_wr && hit(reg_req, `PAGE_CONFIG, `OFF_BALANCE_SETUP)) begin
      next_setup = reg_req.wdata[9:0];
    end
    if (cfg_wr && hit(reg_req, `PAGE_CONFIG, `OFF_WDT_BAL_TIME)) begin
      next_wdt_time = reg_req.wdata;
    end
    if (cfg_wr && hit(reg_req, `PAGE_CONFIG, `OFF_DEVICE_SETUP)) begin
      next_pause_en = reg_req.wdata[`MEASURE_PAUSE_BIT];
    end
    if (cmd_acc && hit(reg_req, `PAGE_COMMAND, `CMD_BALANCE_ENABLE)) begin
      next_setup[`ENABLE_BIT] = 1'b1;
    end
    if (cmd_acc && hit(reg_req, `PAGE_COMMAND, `CMD_BALANCE_INHIBIT)) begin
      next_setup[`ENABLE_BIT] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      setup    <= `SETUP_RESET;
      wdt_time <= `WDT_BAL_TIME_RESET;
      pause_en <= 1'b0;
    end else if (ce) begin
      setup    <= next_setup;
      wdt_time <= next_wdt_time;
      pause_en <= next_pause_en;
    end
  end

  bal_mode_e   mode;
  logic [3:0]  pointer;
  logic        enable;
  logic [11:0] time_secs;
  logic [11:0] wait_secs;

  assign mode      = bal_mode_e'(setup[`MODE_MSB:`MODE_LSB]);
  assign pointer   = setup[`POINTER_MSB:`POINTER_LSB];
  assign enable    = setup[`ENABLE_BIT];
  // each time code step is 20 s, so 3 is one minute and 15 five minutes
  assign time_secs = 12'(wdt_time[`BAL_TIME_MSB:`BAL_TIME_LSB]) * 12'(`BAL_TIME_UNIT_S);
  assign wait_secs = 12'(setup[`WAIT_MSB:`WAIT_LSB]) * 12'(`WAIT_UNIT_S);

  // instance memory: port a follows the host pointer, port b the sequencer
  logic [3:0]  inst;
  logic [11:0] host_pattern;
  logic [11:0] seq_pattern;

  cell_select_mem #(.WIDTH(12), .DEPTH(16), .AW(4)) u_mem (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .ce        (ce),
    .wr_en     (cfg_wr && hit(reg_req, `PAGE_CONFIG, `OFF_CELL_SELECT)),
    .wr_addr   (pointer),
    .wr_data   (reg_req.wdata[11:0]),
    .rd_addr_a (pointer),
    .rd_data_a (host_pattern),
    .rd_addr_b (inst),
    .rd_data_b (seq_pattern)
  );

  // sequencer
  bal_state_e  state;
  bal_state_e  next_state;
  logic [3:0]  next_inst;
  logic [11:0] act_pat;
  logic [11:0] next_act_pat;
  logic [11:0] secs;
  logic [11:0] next_secs;
  logic [31:0] prescale;
  logic [31:0] next_prescale;
  logic        tick;
  logic        sub_now;
  logic [CELLS-1:0] value_zero;
  logic [CELLS-1:0][27:0] all_val;

  assign tick = (prescale == 32'(TICK_CYCLES - 1));

  always_comb begin
    next_state    = state;
    next_inst     = inst;
    next_act_pat  = act_pat;
    next_secs     = secs;
    next_prescale = tick ? 32'h0000_0000 : prescale + 32'h0000_0001;
    sub_now       = 1'b0;
    if (tick && (state == ST_ON || state == ST_WAIT)) begin
      next_secs = secs + 12'h001;
    end
    case (state)
      ST_IDLE: begin
        if (enable && mode != MODE_OFF) begin
          next_inst  = (mode == MODE_AUTO) ? 4'h1 : 4'h0;
          next_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        next_state = ST_LOAD;
      end
      ST_LOAD: begin
        next_secs     = 12'h000;
        next_prescale = 32'h0000_0000;
        if (mode == MODE_AUTO && (&value_zero)) begin
          next_state = ST_DONE;
        end else if (mode == MODE_AUTO && seq_pattern == 12'h000) begin
          if (inst == 4'h1) begin
            next_state = ST_DONE;
          end else begin
            next_inst  = 4'h1;
            next_state = ST_FETCH;
          end
        end else begin
          next_act_pat = seq_pattern;
          next_state   = ST_ON;
        end
      end
      ST_ON: begin
        if (mode == MODE_MANUAL) begin
          next_state = ST_ON;
        end else if (tick && next_secs >= time_secs) begin
          next_secs     = 12'h000;
          next_prescale = 32'h0000_0000;
          if (mode == MODE_TIMED) begin
            next_state = ST_DONE;
          end else begin
            sub_now    = 1'b1;
            next_state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (&value_zero) begin
          next_state = ST_DONE;
        end else if (secs >= wait_secs) begin
          next_inst  = (inst == 4'hF) ? 4'h1 : inst + 4'h1;
          next_state = ST_FETCH;
        end
      end
      ST_DONE: begin
        next_state = ST_DONE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // a stop or a change to MODE_OFF always wins over the running sequence
    if (!enable || mode == MODE_OFF) begin
      next_state = ST_IDLE;
      sub_now    = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state    <= ST_IDLE;
      inst     <= 4'h0;
      act_pat  <= 12'h000;
      secs     <= 12'h000;
      prescale <= 32'h0000_0000;
    end else if (ce) begin
      state    <= next_state;
      inst     <= next_inst;
      act_pat  <= next_act_pat;
      secs     <= next_secs;
      prescale <= next_prescale;
    end
  end

  // balance values, one 28-bit count per cell
  genvar g;
  generate
    for (g = 0; g < CELLS; g++) begin : g_cell
      logic [27:0] val;
      logic [27:0] next_val;
      always_comb begin
        next_val = val;
        if (cfg_wr && hit(reg_req, `PAGE_CONFIG, 6'(`OFF_BAL_VALUE_FIRST + 2 * g))) begin
          next_val[13:0] = reg_req.wdata;
        end else if (cfg_wr && hit(reg_req, `PAGE_CONFIG,
                                   6'(`OFF_BAL_VALUE_FIRST + 2 * g + 1))) begin
          next_val[27:14] = reg_req.wdata;
        end else if (sub_now && act_pat[g]) begin
          next_val = (val > {14'h0000, cell_volt[g]}) ?
                     val - {14'h0000, cell_volt[g]} : 28'h000_0000;
        end
      end
      always_ff @(posedge ref_clk) begin
        if (!rstn) begin
          val <= 28'h000_0000;
        end else if (ce) begin
          val <= next_val;
        end
      end
      assign value_zero[g] = (val == 28'h000_0000);
      assign all_val[g]    = val;
    end
  endgenerate

  // outputs
  logic [11:0] next_switch;
  logic        rd_pend;
  logic [2:0]  rd_page;
  logic [5:0]  rd_addr;
  logic [13:0] next_rdata;
  logic [5:0]  val_idx;

  always_comb begin
    next_switch = 12'h000;
    if (state == ST_ON) begin
      next_switch = act_pat;
      if (mode == MODE_AUTO) begin
        next_switch = act_pat & ~value_zero;
      end
      if (pause_en && meas_busy) begin
        next_switch = 12'h000;
      end
    end
  end

  assign val_idx = rd_addr - `OFF_BAL_VALUE_FIRST;

  always_comb begin
    next_rdata = 14'h0000;
    if (rd_page == `PAGE_CONFIG) begin
      case (rd_addr)
        `OFF_BALANCE_SETUP: next_rdata = {4'h0, setup};
        `OFF_CELL_SELECT:   next_rdata = {2'b00, host_pattern};
        `OFF_WDT_BAL_TIME:  next_rdata = wdt_time;
        `OFF_DEVICE_SETUP:  next_rdata = 14'(pause_en) << `MEASURE_PAUSE_BIT;
        default: begin
          if (rd_addr >= `OFF_BAL_VALUE_FIRST && rd_addr <= `OFF_BAL_VALUE_LAST) begin
            next_rdata = val_idx[0] ? all_val[val_idx[4:1]][27:14]
                                    : all_val[val_idx[4:1]][13:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rd_pend        <= 1'b0;
      rd_page        <= 3'h0;
      rd_addr        <= 6'h00;
      reg_rdata      <= 14'h0000;
      reg_rvalid     <= 1'b0;
      balance_switch <= 12'h000;
      balance_busy   <= 1'b0;
      balance_done   <= 1'b0;
    end else if (ce) begin
      rd_pend        <= reg_req.rd;
      rd_page        <= reg_req.page;
      rd_addr        <= reg_req.addr;
      reg_rdata      <= rd_pend ? next_rdata : 14'h0000;
      reg_rvalid     <= rd_pend;
      balance_switch <= next_switch;
      balance_busy   <= (next_state != ST_IDLE) && (next_state != ST_DONE);
      balance_done   <= (next_state == ST_DONE);
    end
  end

endmodule // cell_balance_ctrl
`default_nettype wire

// >>> tb/cell_balance_monitor.sv
// port checker for the balance controller
// assumes ce held high and commands sent one per access
`timescale 1ns/1ps
`default_nettype none
module cell_balance_monitor
  import cell_balance_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire reg_req_s    reg_req,
  input wire logic [13:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic [11:0] balance_switch,
  input wire logic        balance_busy,
  input wire logic        balance_done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic setup_wr, cmd_on, cmd_off, idle, en_wr, off_wr, sw_on;
  assign setup_wr = reg_req.wr && reg_req.page == 3'h2 && reg_req.addr == 6'h13;
  assign cmd_on   = (reg_req.wr || reg_req.rd) && reg_req.page == 3'h3 && reg_req.addr == 6'h10;
  assign cmd_off  = (reg_req.wr || reg_req.rd) && reg_req.page == 3'h3 && reg_req.addr == 6'h11;
  assign idle     = !balance_busy && !balance_done;
  assign en_wr    = setup_wr && reg_req.wdata[9] && reg_req.wdata[1:0] != 2'b00;
  assign off_wr   = setup_wr && !reg_req.wdata[9];
  assign sw_on    = |balance_switch;
  read_latency_a: assert property (reg_req.rd && reg_req.page == 3'h2 |-> ##2 reg_rvalid)
    else $error("read answer missing");
  read_cause_a: assert property (reg_rvalid |-> $past(reg_req.rd, 2))
    else $error("answer without read");
  rdata_idle_a: assert property (!reg_rvalid |-> reg_rdata == 14'h0000)
    else $error("read data outside answer");
  enable_start_a: assert property (en_wr && idle |-> ##4 balance_busy)
    else $error("enable bit did not start");
  cmd_start_a: assert property (cmd_on && idle |-> ##4 balance_busy)
    else $error("enable command did not start");
  // the switch register trails the state register by one cycle after a stop
  inhibit_stop_a: assert property (cmd_off |-> ##3 !sw_on)
    else $error("inhibit left switches on");
  clear_stop_a: assert property (off_wr |-> ##3 !sw_on)
    else $error("clearing enable left switches on");
  done_off_a: assert property (balance_done && $past(balance_done) |-> !sw_on)
    else $error("switch on after done");
  switch_rise_a: assert property ($rose(|balance_switch) |-> balance_busy)
    else $error("switch on while not busy");
  cover property (cmd_on && idle);
  cover property ($rose(balance_done));
  cover property ($fell(|balance_switch) && balance_busy);
endmodule // cell_balance_monitor
bind cell_balance_ctrl cell_balance_monitor mon (.ref_clk(ref_clk), .rstn(rstn),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .balance_switch(balance_switch), .balance_busy(balance_busy), .balance_done(balance_done));
`default_nettype wire

// >>> tb/host_model.sv
// host side model: register writes, reads and commands
// assumes answers two cycles after a read; drives at the falling edge
`timescale 1ns/1ps
`default_nettype none
module host_model
  import cell_balance_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic [13:0] reg_rdata,
  input  wire logic        reg_rvalid,
  output var reg_req_s     reg_req
);
  initial reg_req = '0;
  task automatic acc(input logic w, input logic [2:0] pg, input logic [5:0] a,
                     input logic [13:0] d);
    @(negedge ref_clk);
    reg_req = '{w, !w, pg, a, d};
    @(negedge ref_clk);
    reg_req = '0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [13:0] d);
    acc(1'b1, 3'h2, a, d);
  endtask
  task automatic rd(input logic [5:0] a, output logic [13:0] q);
    int n;
    acc(1'b0, 3'h2, a, 14'h0000);
    for (n = 0; n < 4 && !reg_rvalid; n++) @(negedge ref_clk);
    // a missing answer reads as unknown so no compare can pass it
    q = reg_rvalid ? reg_rdata : 'x;
  endtask
  // commands carry no data, sent as reads
  task automatic cmd(input logic [5:0] a);
    acc(1'b0, 3'h3, a, 14'h0000);
  endtask
  // pointer zero and enable clear before the pattern
  task automatic setup(input logic [1:0] mode, input logic [11:0] pat);
    wr(6'h13, {12'h000, mode});
    wr(6'h14, {2'b00, pat});
  endtask
  // auto mode, wait field 100, pointer set before each pattern
  task automatic inst(input logic [3:0] p, input logic [11:0] pat);
    wr(6'h13, {5'h00, p, 5'h13});
    wr(6'h14, {2'b00, pat});
  endtask
  task automatic value(input int c, input logic [27:0] v);
    logic [5:0] o;
    o = 6'h20 + 6'(2 * c - 2);
    wr(o, v[13:0]);
    wr(o + 6'h01, v[27:14]);
  endtask
endmodule // host_model
`default_nettype wire

// >>> tb/cell_balance_ctrl_test.sv
// self-checking bench for the balance controller
// assumes a 4-cycle balance tick so balance times stay short
`timescale 1ns/1ps
`default_nettype none
module cell_balance_controller_test;
  import cell_balance_pkg::*;
  localparam int TICK = 4;
  logic       ref_clk, rstn, ce, meas_busy, reg_rvalid, balance_busy, balance_done;
  reg_req_s   reg_req;
  cell_volt_t cell_volt;
  logic [13:0] reg_rdata;
  logic [11:0] balance_switch;
  int          error_cnt, cmp_count, n, i;
  logic [6:0]  codes [2] = '{7'h03, 7'h0F};
  logic [11:0] pats [4] = '{12'h249, 12'h924, 12'h492, 12'h001};

  cell_balance_ctrl #(.CELLS(12), .TICK_CYCLES(TICK)) dut (.ref_clk(ref_clk), .rstn(rstn),
    .ce(ce), .reg_req(reg_req), .cell_volt(cell_volt), .meas_busy(meas_busy),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .balance_switch(balance_switch),
    .balance_busy(balance_busy), .balance_done(balance_done));
  host_model host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_req(reg_req));

  initial ref_clk = 1'b0;
  always #50 ref_clk = ~ref_clk;

  task automatic chk(input string what, input logic [27:0] seen, input logic [27:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(input logic [5:0] a, input logic [13:0] exp);
    logic [13:0] q;
    host.rd(a, q);
    chk("register", 28'(q), 28'(exp));
  endtask
  task automatic sw(input logic [11:0] exp);
    chk("switch", 28'(balance_switch), 28'(exp));
  endtask
  task automatic wait_sw(input logic on, output int k);
    k = 0;
    while (((balance_switch != 12'h000) !== on) && k < 400) begin
      @(negedge ref_clk);
      k++;
    end
    chk("switch wait", 28'(k < 400), 28'h1);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // the whole run is about 2200 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    meas_busy = 1'b0;
    cell_volt = {12{14'h0010}};
    error_cnt = 0;
    cmp_count = 0;
    repeat (12) @(negedge ref_clk);
    rstn = 1'b1;
    rchk(6'h13, 14'h0000);
    rchk(6'h15, 14'h0000);
    host.wr(6'h13, 14'h3C1C);
    rchk(6'h13, 14'h001C);
    host.wr(6'h15, 14'h3FFF);
    rchk(6'h15, 14'h3FFF);
    rchk(6'h3F, 14'h0000);
    $display("registers done");
    host.setup(2'b01, 12'h451);
    rchk(6'h14, 14'h0451);
    host.cmd(6'h10);
    repeat (6) @(negedge ref_clk);
    sw(12'h451);
    chk("busy", 28'(balance_busy), 28'h1);
    repeat (50) @(negedge ref_clk);
    sw(12'h451);
    host.cmd(6'h11);
    repeat (3) @(negedge ref_clk);
    sw(12'h000);
    host.wr(6'h13, 14'h0201);
    repeat (6) @(negedge ref_clk);
    sw(12'h451);
    host.wr(6'h13, 14'h0001);
    repeat (3) @(negedge ref_clk);
    sw(12'h000);
    $display("manual done");
    foreach (codes[j]) begin
      host.setup(2'b10, 12'h082);
      host.wr(6'h15, {codes[j], 7'h7F});
      host.cmd(6'h10);
      repeat (int'(codes[j]) * 20 * TICK - 12) @(negedge ref_clk);
      sw(12'h082);
      repeat (20) @(negedge ref_clk);
      sw(12'h000);
      chk("done", 28'(balance_done), 28'h1);
      chk("busy", 28'(balance_busy), 28'h0);
      host.wr(6'h13, 14'h0002);
    end
    $display("timed done");
    host.wr(6'h19, 14'h0080);
    host.wr(6'h15, 14'h00FF);
    for (i = 1; i <= 12; i++) host.value(i, 28'h10);
    host.value(1, 28'h20);
    host.value(12, 28'h00136CA);
    rchk(6'h36, 14'h36CA);
    rchk(6'h37, 14'h0004);
    host.value(12, 28'h10);
    host.inst(4'h1, 12'h249);
    host.inst(4'h2, 12'h924);
    host.inst(4'h3, 12'h492);
    rchk(6'h14, 14'h0492);
    host.inst(4'h4, 12'h000);
    host.wr(6'h13, 14'h0293);
    for (i = 0; i < 4; i++) begin
      wait_sw(1'b1, n);
      if (i > 0) chk("wait gap", 28'(n >= 32 && n <= 44), 28'h1);
      sw(pats[i]);
      if (i == 0) begin
        meas_busy = 1'b1;
        repeat (3) @(negedge ref_clk);
        sw(12'h000);
        meas_busy = 1'b0;
        repeat (3) @(negedge ref_clk);
      end
      wait_sw(1'b0, n);
    end
    for (n = 0; n < 200 && balance_done !== 1'b1; n++) @(negedge ref_clk);
    chk("done", 28'(balance_done), 28'h1);
    sw(12'h000);
    $display("auto done");
    summarize();
  end
endmodule // cell_balance_controller_test
`default_nettype wire
